// >>> design/pw_policy_pkg.sv
// Constants for the pseudowire TDM defect policy block.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package pw_policy_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_TOS    = 8'h04;
  localparam logic [7:0] OFF_PT     = 8'h08;
  localparam logic [7:0] OFF_TSREF  = 8'h0C;
  localparam logic [7:0] OFF_POLICY = 8'h10;
  localparam logic [7:0] OFF_IDLE   = 8'h14;
  localparam logic [7:0] OFF_LINE   = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_TSNOW  = 8'h20;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_CTRL   = 32'h0002_0000;
  localparam logic [31:0] RST_TOS    = 32'h0000_00B8;
  localparam logic [31:0] RST_PT     = 32'h0000_0000;
  localparam logic [31:0] RST_TSREF  = 32'h0001_0001;
  localparam logic [31:0] RST_POLICY = 32'h0100_0000;
  localparam logic [31:0] RST_IDLE   = 32'h0505_0FFF;
  localparam logic [31:0] RST_LINE   = 32'h0105_0101;

  //////////////////////////////////////////////////////////////////////////////
  // Field defaults and codes
  localparam logic [7:0] SRTP_ON      = 8'h01;
  localparam logic [7:0] LFLAG_USE    = 8'h01;
  localparam logic [7:0] SIG_IVL_DEF  = 8'h05;
  localparam logic [7:0] SIG_MAX_DEF  = 8'h05;
  localparam logic [7:0] LOPS_DEF     = 8'h01;
  localparam logic [7:0] LINE_MAX     = 8'h09;
  localparam logic [7:0] CODE_MAX     = 8'h07;
  localparam logic [7:0] LOOP_MAX     = 8'h06;
  localparam logic [7:0] LINE_DEF     = 8'h01;
  localparam logic [7:0] CODE_DEF     = 8'h05;
  localparam logic [7:0] LOOP_DEF     = 8'h01;
  localparam logic [1:0] MBITS_RDI    = 2'h1;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int TS_PERIOD_NS = 125_000;
  localparam int MS_NS       = 1_000_000;
  localparam int TS_CYCLES   = TS_PERIOD_NS / (1_000_000_000 / CLK_HZ);
  localparam int MS_CYCLES   = MS_NS / (1_000_000_000 / CLK_HZ);
  localparam int MS_PER_S    = 1000;

  typedef enum logic [2:0] {ACT_PASS, ACT_IDLE, ACT_AIS, ACT_CHIDLE, ACT_RAI} tdm_action_e;

endpackage

// >>> design/pw_tdm_defect_policy.sv
// Pseudowire TDM policy: header values, receive checks, TDM playout choice,
// CAS signaling timing and line settings. Assumes receive and defect inputs
// come from logic on the same clock; registers sit on AXI4-Lite.
`timescale 1ns/10ps
module pw_tdm_defect_policy #(
  parameter int TS_TICK = pw_policy_pkg::TS_CYCLES,
  parameter int MS_TICK = pw_policy_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Received packet header, one-cycle strobe
  input  wire logic        rxValid,
  input  wire logic        rxSignaling,
  input  wire logic        rxLFlag,
  input  wire logic        rxRFlag,
  input  wire logic [1:0]  rxMBits,
  input  wire logic [6:0]  rxPt,
  input  wire logic [31:0] rxTs,
  // Defect state
  input  wire logic        lopsActive,
  input  wire logic        tdmFail,
  input  wire logic        sigChange,
  input  wire logic [7:0]  sigState,
  // Transmit header values
  output logic [7:0]       txTos,
  output logic [7:0]       txSigTos,
  output logic [7:0]       txPt,
  output logic [7:0]       txSigPt,
  output logic [31:0]      txTimestamp,
  output logic             txLFlag,
  output logic             srtpEnable,
  // Receive verdict
  output logic             rxAccept,
  output logic             rxPayloadUse,
  output logic [31:0]      rxTsOffset,
  // TDM playout
  output logic [2:0]       tdmAction,
  output logic [7:0]       tdmFill,
  // CAS signaling stream
  output logic [7:0]       sigTxByte,
  output logic             sigSend,
  // Line settings
  output logic [7:0]       linePort,
  output logic [7:0]       lineType,
  output logic [7:0]       lineCoding,
  output logic [7:0]       lineLoop
);

  generate
    if (TS_TICK < 1 || MS_TICK < 1) begin : g_chk
      $error("Tick counts must be at least one cycle");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0] ctrl_r, tos_r, pt_r, tsref_r, policy_r, idle_r, line_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        awHeld_r, wHeld_r;
  logic        rejected_r;
  logic        remoteSeen_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == pw_policy_pkg::OFF_CTRL || a == pw_policy_pkg::OFF_TOS || a == pw_policy_pkg::OFF_PT
        || a == pw_policy_pkg::OFF_TSREF || a == pw_policy_pkg::OFF_POLICY || a == pw_policy_pkg::OFF_IDLE
        || a == pw_policy_pkg::OFF_LINE || a == pw_policy_pkg::OFF_STATUS || a == pw_policy_pkg::OFF_TSNOW;
  endfunction

  wire doWrite = awHeld_r && wHeld_r && !bvalid;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= pw_policy_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr_r <= awaddr;
        awHeld_r <= 1'b1;
        awready  <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_r <= wdata;
        wStrb_r <= wstrb;
        wHeld_r <= 1'b1;
        wready  <= 1'b0;
      end
      if (doWrite) begin
        bvalid   <= 1'b1;
        bresp    <= mapped(awAddr_r) ? pw_policy_pkg::RESP_OKAY : pw_policy_pkg::RESP_SLVERR;
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_r   <= pw_policy_pkg::RST_CTRL;
      tos_r    <= pw_policy_pkg::RST_TOS;
      pt_r     <= pw_policy_pkg::RST_PT;
      tsref_r  <= pw_policy_pkg::RST_TSREF;
      policy_r <= pw_policy_pkg::RST_POLICY;
      idle_r   <= pw_policy_pkg::RST_IDLE;
      line_r   <= pw_policy_pkg::RST_LINE;
    end else if (doWrite) begin
      case (awAddr_r)
        pw_policy_pkg::OFF_CTRL:   ctrl_r   <= merge(ctrl_r, wData_r, wStrb_r);
        pw_policy_pkg::OFF_TOS:    tos_r    <= merge(tos_r, wData_r, wStrb_r);
        pw_policy_pkg::OFF_PT:     pt_r     <= merge(pt_r, wData_r, wStrb_r);
        pw_policy_pkg::OFF_TSREF:  tsref_r  <= merge(tsref_r, wData_r, wStrb_r);
        pw_policy_pkg::OFF_POLICY: policy_r <= merge(policy_r, wData_r, wStrb_r);
        pw_policy_pkg::OFF_IDLE:   idle_r   <= merge(idle_r, wData_r, wStrb_r);
        pw_policy_pkg::OFF_LINE:   line_r   <= merge(line_r, wData_r, wStrb_r);
        default: ;
      endcase
    end
  end

  // Read path; one answer outstanding at a time
  always_ff @(posedge clock) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= pw_policy_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= mapped(araddr) ? pw_policy_pkg::RESP_OKAY : pw_policy_pkg::RESP_SLVERR;
      case (araddr)
        pw_policy_pkg::OFF_CTRL:   rdata <= ctrl_r;
        pw_policy_pkg::OFF_TOS:    rdata <= tos_r;
        pw_policy_pkg::OFF_PT:     rdata <= pt_r;
        pw_policy_pkg::OFF_TSREF:  rdata <= tsref_r;
        pw_policy_pkg::OFF_POLICY: rdata <= policy_r;
        pw_policy_pkg::OFF_IDLE:   rdata <= idle_r;
        pw_policy_pkg::OFF_LINE:   rdata <= line_r;
        pw_policy_pkg::OFF_STATUS: rdata <= {21'h0, lopsActive, remoteSeen_r, rejected_r, tdmFail, tdmAction, 4'h0};
        pw_policy_pkg::OFF_TSNOW:  rdata <= txTimestamp;
        default:                   rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field views with out-of-range values folded to defaults
  // Default on bad codes
  wire [7:0] lPol    = policy_r[7:0]   > 8'h02 ? 8'h00 : policy_r[7:0];
  wire [7:0] rPol    = policy_r[15:8]  > 8'h02 ? 8'h00 : policy_r[15:8];
  wire [7:0] mPol    = policy_r[23:16] > 8'h02 ? 8'h00 : policy_r[23:16];
  wire [7:0] lopsPol = (policy_r[31:24] == 8'h00 || policy_r[31:24] > 8'h03) ? pw_policy_pkg::LOPS_DEF
                       : policy_r[31:24];
  wire       lUse    = ctrl_r[7:0] == pw_policy_pkg::LFLAG_USE;
  wire       sepSig  = ctrl_r[16];
  wire       admDis  = ctrl_r[17];
  wire [7:0] sigIvl  = idle_r[23:16] == 8'h00 ? pw_policy_pkg::SIG_IVL_DEF : idle_r[23:16];
  wire [7:0] sigMax  = idle_r[31:24] == 8'h00 ? pw_policy_pkg::SIG_MAX_DEF : idle_r[31:24];

  //////////////////////////////////////////////////////////////////////////////
  // Transmit header values and line settings
  always_ff @(posedge clock) begin
    if (!nrst) begin
      txTos      <= pw_policy_pkg::RST_TOS[7:0];
      txSigTos   <= 8'h00;
      txPt       <= 8'h00;
      txSigPt    <= 8'h00;
      txLFlag    <= 1'b0;
      srtpEnable <= 1'b0;
      linePort   <= pw_policy_pkg::RST_LINE[7:0];
      lineType   <= pw_policy_pkg::LINE_DEF;
      lineCoding <= pw_policy_pkg::CODE_DEF;
      lineLoop   <= pw_policy_pkg::LOOP_DEF;
    end else begin
      txTos    <= tos_r[7:0];
      txSigTos <= tos_r[15:8];
      txPt     <= pt_r[7:0];
      txSigPt  <= pt_r[23:16];
      txLFlag  <= tdmFail;
      srtpEnable <= ctrl_r[15:8] == pw_policy_pkg::SRTP_ON;
      linePort <= line_r[7:0];
      lineType <= (line_r[15:8] == 8'h00 || line_r[15:8] > pw_policy_pkg::LINE_MAX)
                  ? pw_policy_pkg::LINE_DEF : line_r[15:8];
      lineCoding <= (line_r[23:16] == 8'h00 || line_r[23:16] > pw_policy_pkg::CODE_MAX)
                    ? pw_policy_pkg::CODE_DEF : line_r[23:16];
      lineLoop <= (line_r[31:24] == 8'h00 || line_r[31:24] > pw_policy_pkg::LOOP_MAX)
                  ? pw_policy_pkg::LOOP_DEF : line_r[31:24];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 125 us tick and timestamps
  logic [$clog2(TS_TICK+1)-1:0] tsDiv_r;
  logic        tsTick_r;
  logic [31:0] peerTs_r;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tsDiv_r  <= '0;
      tsTick_r <= 1'b0;
    end else begin
      tsTick_r <= tsDiv_r == $bits(tsDiv_r)'(TS_TICK - 1);
      tsDiv_r  <= tsDiv_r == $bits(tsDiv_r)'(TS_TICK - 1) ? '0 : tsDiv_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      txTimestamp <= 32'h0000_0000;
      peerTs_r    <= 32'h0000_0000;
    end else if (tsTick_r) begin
      txTimestamp <= txTimestamp + {16'h0000, tsref_r[15:0]};
      peerTs_r    <= peerTs_r + {16'h0000, tsref_r[31:16]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive checks
  wire [7:0] expPt  = rxSignaling ? pt_r[31:24] : pt_r[15:8];
  wire       ptBad  = expPt != 8'h00 && expPt != {1'b0, rxPt};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rxAccept     <= 1'b0;
      rxPayloadUse <= 1'b0;
      rxTsOffset   <= 32'h0000_0000;
      rejected_r   <= 1'b0;
    end else if (rxValid) begin
      // Data type check; signaling type check
      rxAccept     <= !ptBad;
      rejected_r   <= ptBad;
      // L flag payload keep or drop
      rxPayloadUse <= !ptBad && (!rxLFlag || lUse);
      rxTsOffset   <= rxTs - peerTs_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // TDM playout choice; latest accepted data packet steers it
  pw_policy_pkg::tdm_action_e pktAct_r, act_nxt;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pktAct_r     <= pw_policy_pkg::ACT_PASS;
      remoteSeen_r <= 1'b0;
    end else if (rxValid && !rxSignaling && !ptBad) begin
      remoteSeen_r <= !rxLFlag && (rxRFlag || rxMBits == pw_policy_pkg::MBITS_RDI);
      if (rxLFlag) begin
        case (lPol)
          8'h01:   pktAct_r <= pw_policy_pkg::ACT_AIS;
          8'h02:   pktAct_r <= pw_policy_pkg::ACT_CHIDLE;
          default: pktAct_r <= pw_policy_pkg::ACT_IDLE;
        endcase
      end else if (rxMBits == pw_policy_pkg::MBITS_RDI) begin
        case (mPol)
          8'h01:   pktAct_r <= pw_policy_pkg::ACT_RAI;
          8'h02:   pktAct_r <= pw_policy_pkg::ACT_CHIDLE;
          default: pktAct_r <= pw_policy_pkg::ACT_PASS;
        endcase
      end else if (rxRFlag) begin
        case (rPol)
          8'h01:   pktAct_r <= pw_policy_pkg::ACT_RAI;
          8'h02:   pktAct_r <= pw_policy_pkg::ACT_CHIDLE;
          default: pktAct_r <= pw_policy_pkg::ACT_PASS;
        endcase
      end else begin
        pktAct_r <= pw_policy_pkg::ACT_PASS;
      end
    end
  end

  always_comb begin
    act_nxt = pktAct_r;
    if (admDis) begin
      act_nxt = pw_policy_pkg::ACT_IDLE;
    end else if (lopsActive) begin
      case (lopsPol)
        8'h02:   act_nxt = pw_policy_pkg::ACT_AIS;
        8'h03:   act_nxt = pw_policy_pkg::ACT_CHIDLE;
        default: act_nxt = pw_policy_pkg::ACT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tdmAction <= 3'(pw_policy_pkg::ACT_PASS);
      tdmFill   <= pw_policy_pkg::RST_IDLE[7:0];
    end else begin
      tdmAction <= 3'(act_nxt);
      tdmFill   <= idle_r[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // CAS signaling stream timing
  logic [$clog2(MS_TICK+1)-1:0] msDiv_r;
  logic       msTick_r;
  logic [7:0] ivlCnt_r;
  logic [9:0] msInS_r;
  logic [7:0] secCnt_r;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      msDiv_r  <= '0;
      msTick_r <= 1'b0;
    end else begin
      msTick_r <= msDiv_r == $bits(msDiv_r)'(MS_TICK - 1);
      msDiv_r  <= msDiv_r == $bits(msDiv_r)'(MS_TICK - 1) ? '0 : msDiv_r + 1'b1;
    end
  end

  // Interval and refresh only run in separate-stream mode
  wire ivlHit = msTick_r && ivlCnt_r >= sigIvl - 8'h01;
  wire secHit = msTick_r && msInS_r == 10'(pw_policy_pkg::MS_PER_S - 1);
  wire refHit = secHit && secCnt_r >= sigMax - 8'h01;

  always_ff @(posedge clock) begin
    if (!nrst || !sepSig) begin
      ivlCnt_r <= 8'h00;
      msInS_r  <= 10'h000;
      secCnt_r <= 8'h00;
      sigSend  <= 1'b0;
    end else begin
      ivlCnt_r <= msTick_r ? (ivlHit ? 8'h00 : ivlCnt_r + 8'h01) : ivlCnt_r;
      msInS_r  <= sigChange ? 10'h000 : (msTick_r ? (secHit ? 10'h000 : msInS_r + 10'h001) : msInS_r);
      secCnt_r <= (sigChange || refHit) ? 8'h00 : (secHit ? secCnt_r + 8'h01 : secCnt_r);
      sigSend  <= ivlHit || (refHit && !sigChange) || sigChange;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sigTxByte <= pw_policy_pkg::RST_IDLE[15:8];
    end else begin
      sigTxByte <= tdmFail ? idle_r[15:8] : sigState;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_lpkt;
    rxValid && !rxSignaling && !ptBad && rxLFlag && !admDis && !lopsActive;
  endsequence

  a_tos_follow: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> txTos == $past(tos_r[7:0]))
    else $error("Data TOS not following register");

  a_lflag_drop: assert property (@(posedge clock) disable iff (!nrst)
    (rxValid && rxLFlag && !lUse) |=> !rxPayloadUse)
    else $error("L flag payload not dropped");

  a_pt_reject: assert property (@(posedge clock) disable iff (!nrst)
    (rxValid && !rxSignaling && pt_r[15:8] != 8'h00 && pt_r[15:8] != {1'b0, rxPt}) |=> !rxAccept)
    else $error("Wrong payload type accepted");

  a_ts_step: assert property (@(posedge clock) disable iff (!nrst)
    tsTick_r |=> txTimestamp == $past(txTimestamp) + {16'h0000, $past(tsref_r[15:0])})
    else $error("Timestamp step wrong");

  a_lpol_ais: assert property (@(posedge clock) disable iff (!nrst)
    s_lpkt ##0 (lPol == 8'h01) ##1 (!admDis && !lopsActive) |=> tdmAction == 3'(pw_policy_pkg::ACT_AIS))
    else $error("L policy AIS not applied");

  a_lops_idle: assert property (@(posedge clock) disable iff (!nrst)
    (lopsActive && !admDis && lopsPol == 8'h01) |=> tdmAction == 3'(pw_policy_pkg::ACT_IDLE))
    else $error("LOPS idle not applied");

  a_sig_idle: assert property (@(posedge clock) disable iff (!nrst)
    tdmFail |=> sigTxByte == $past(idle_r[15:8]))
    else $error("Signaling idle not sent");

  a_srtp_map: assert property (@(posedge clock) disable iff (!nrst)
    (ctrl_r[15:8] == 8'h02) [*2] |-> !srtpEnable)
    else $error("SRTP not disabled");

  a_sig_quiet: assert property (@(posedge clock) disable iff (!nrst)
    !sepSig |=> !sigSend)
    else $error("Signaling sent outside separate mode");

endmodule

// >>> tb/pw_peer_model.sv
// Remote pseudowire endpoint: one received header per bench request.
// Assumes requests come on the shared clock, one edge at a time.
`timescale 1ns/10ps
module pw_peer_model (
  // Clock and request
  input  wire logic       clock,
  input  wire logic       send,
  input  wire logic [3:0] hdr,
  input  wire logic [6:0] pt,
  // Header toward the block
  output logic            rxValid = 1'h0,
  output logic            rxLFlag = 1'h0,
  output logic            rxRFlag = 1'h0,
  output logic [1:0]      rxMBits = 2'h0,
  output logic [6:0]      rxPt = 7'h00,
  output logic [31:0]     rxTs = 32'h0
);
  // sender marks own failure
  // L, R, M and PT fields invert between headers so stale values never pass as valid; rxTs counts up every cycle
  always_ff @(posedge clock) begin
    rxValid <= send;
    {rxLFlag, rxRFlag, rxMBits} <= send ? hdr : ~{rxLFlag, rxRFlag, rxMBits};
    rxPt <= send ? pt : ~rxPt;
    rxTs <= rxTs + 32'h1;
  end
endmodule

// >>> tb/pseudowire_tdm_defect_policy_test.sv
// Bench: table of defect cases, then line, timestamp and signaling checks.
// Assumes tick parameters shortened to 10 and 20 cycles.
`timescale 1ns/10ps
module pseudowire_tdm_defect_policy_test;
  logic        clock = 1'h0, nrst = 1'h0, send = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic        bready = 1'h0, arvalid = 1'h0, rready = 1'h0, lopsActive = 1'h0, tdmFail = 1'h0;
  logic        rxSignaling = 1'h0, sigChange = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sigState = 8'h5A;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF, hdr = 4'h0;
  logic [6:0]  pt = 7'h00, rxPt;
  logic        awready, wready, bvalid, arready, rvalid, rxValid, rxLFlag, rxRFlag, txLFlag;
  logic        srtpEnable, rxAccept, rxPayloadUse, sigSend;
  logic [1:0]  bresp, rresp, rxMBits, rs;
  logic [31:0] rdata, rxTs, txTimestamp, rxTsOffset, d, t0;
  logic [7:0]  txTos, txSigTos, txPt, txSigPt, tdmFill, sigTxByte, linePort, lineType, lineCoding, lineLoop;
  logic [2:0]  tdmAction;
  int          fail_count = 0, n_checks = 0, k;
  // Policy word, header {L,R,M}, expected action
  logic [38:0] rows [10] = '{{32'h0, 4'h8, 3'h1}, {32'h1, 4'h8, 3'h2}, {32'h2, 4'h8, 3'h3},
    {32'h7, 4'h8, 3'h1}, {32'h0, 4'h4, 3'h0}, {32'h100, 4'h4, 3'h4}, {32'h200, 4'h4, 3'h3},
    {32'h10000, 4'h1, 3'h4}, {32'h20000, 4'h1, 3'h3}, {32'h10001, 4'h9, 3'h2}};

  always #12.5 clock = ~clock;
  pw_tdm_defect_policy #(.TS_TICK(10), .MS_TICK(20)) u_dut (
    .clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxValid(rxValid), .rxSignaling(rxSignaling), .rxLFlag(rxLFlag), .rxRFlag(rxRFlag),
    .rxMBits(rxMBits), .rxPt(rxPt), .rxTs(rxTs), .lopsActive(lopsActive), .tdmFail(tdmFail),
    .sigChange(sigChange), .sigState(sigState), .txTos(txTos), .txSigTos(txSigTos), .txPt(txPt),
    .txSigPt(txSigPt), .txTimestamp(txTimestamp), .txLFlag(txLFlag), .srtpEnable(srtpEnable),
    .rxAccept(rxAccept), .rxPayloadUse(rxPayloadUse), .rxTsOffset(rxTsOffset), .tdmAction(tdmAction),
    .tdmFill(tdmFill), .sigTxByte(sigTxByte), .sigSend(sigSend), .linePort(linePort), .lineType(lineType),
    .lineCoding(lineCoding), .lineLoop(lineLoop));
  pw_peer_model u_peer (.clock(clock), .send(send), .hdr(hdr), .pt(pt), .rxValid(rxValid), .rxLFlag(rxLFlag),
    .rxRFlag(rxRFlag), .rxMBits(rxMBits), .rxPt(rxPt), .rxTs(rxTs));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'h0;
    // Let header outputs follow the new register
    repeat (2) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge clock);
  endtask

  task automatic pkt(input logic [3:0] h, input logic [6:0] p);
    hdr <= h;
    pt <= p;
    send <= 1'h1;
    @(posedge clock);
    send <= 1'h0;
    repeat (4) @(posedge clock);
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    chk(txTos, 8'hB8);
    chk(tdmFill, 8'hFF);
    chk(sigTxByte, 8'h0F);
    rd(pw_policy_pkg::OFF_POLICY, d, rs);
    chk(d, 32'h0100_0000);
    wr(pw_policy_pkg::OFF_CTRL, 32'h0);
    foreach (rows[i]) begin
      wr(pw_policy_pkg::OFF_POLICY, rows[i][38:7]);
      pkt(rows[i][6:3], 7'h00);
      chk(tdmAction, rows[i][2:0]);
    end
    lopsActive <= 1'h1;
    wr(pw_policy_pkg::OFF_POLICY, 32'h0200_0000);
    chk(tdmAction, 3'h2);
    wr(pw_policy_pkg::OFF_POLICY, 32'h0900_0000);
    chk(tdmAction, 3'h1);
    lopsActive <= 1'h0;
    wr(pw_policy_pkg::OFF_CTRL, 32'h0000_0101);
    chk(srtpEnable, 1'h1);
    pkt(4'h8, 7'h00);
    chk(rxPayloadUse, 1'h1);
    wr(pw_policy_pkg::OFF_CTRL, 32'h0000_0200);
    chk(srtpEnable, 1'h0);
    pkt(4'h8, 7'h00);
    chk(rxPayloadUse, 1'h0);
    wr(pw_policy_pkg::OFF_PT, 32'h0000_2260);
    chk(txPt, 8'h60);
    pkt(4'h0, 7'h21);
    chk(rxAccept, 1'h0);
    pkt(4'h0, 7'h22);
    chk(rxAccept, 1'h1);
    wr(pw_policy_pkg::OFF_PT, 32'h3340_2260);
    chk(txSigPt, 8'h40);
    rxSignaling <= 1'h1;
    pkt(4'h8, 7'h22);
    chk({rxAccept, tdmAction}, 4'h0);
    pkt(4'h8, 7'h33);
    chk({rxAccept, tdmAction}, 4'h8);
    rxSignaling <= 1'h0;
    wr(pw_policy_pkg::OFF_TOS, 32'h0000_2A2E);
    chk({txSigTos, txTos}, 16'h2A2E);
    wr(pw_policy_pkg::OFF_LINE, 32'h0607_0902);
    chk({linePort, lineType, lineCoding, lineLoop}, 32'h0209_0706);
    wr(pw_policy_pkg::OFF_LINE, 32'h070A_0A03);
    chk({linePort, lineType, lineCoding, lineLoop}, 32'h0301_0501);
    wr(pw_policy_pkg::OFF_TSREF, 32'h0004_00C1);
    t0 = txTimestamp;
    repeat (10) @(posedge clock);
    chk(txTimestamp - t0, 32'h0000_00C1);
    // Headers ten cycles apart: one tick of peer rate 4 against ten peer counts
    pkt(4'h0, 7'h22);
    d = rxTsOffset;
    repeat (5) @(posedge clock);
    pkt(4'h0, 7'h22);
    chk(rxTsOffset - d, 32'h0000_0006);
    tdmFail <= 1'h1;
    repeat (3) @(posedge clock);
    chk({txLFlag, sigTxByte}, 9'h10F);
    tdmFail <= 1'h0;
    wr(pw_policy_pkg::OFF_CTRL, 32'h0001_0000);
    chk(sigTxByte, 8'h5A);
    k = 0;
    repeat (500) begin
      @(posedge clock);
      k += sigSend;
    end
    chk(32'(k), 32'h5);
    // Slow interval, one second refresh; toggling stream mode restarts both counters
    wr(pw_policy_pkg::OFF_IDLE, 32'h01FF_0FFF);
    wr(pw_policy_pkg::OFF_CTRL, 32'h0);
    wr(pw_policy_pkg::OFF_CTRL, 32'h0001_0000);
    k = 0;
    repeat (20200) begin
      @(posedge clock);
      k += sigSend;
    end
    chk(32'(k), 32'h4);
    sigChange <= 1'h1;
    @(posedge clock);
    sigChange <= 1'h0;
    @(posedge clock);
    chk(sigSend, 1'h1);
    nrst <= 1'h0;
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    chk({lineType, lineCoding, lineLoop, 5'h00, tdmAction}, 32'h0105_0100);
    @(posedge clock);
    chk(tdmAction, 3'h1);
    wr(8'h3C, 32'h1);
    chk(rs, pw_policy_pkg::RESP_SLVERR);
    rd(8'h3C, d, rs);
    chk(rs, pw_policy_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    conclude;
  end

  // Watchdog well past the expected run of about 21000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    conclude;
  end
endmodule
